// ---- hw/vtc_csr_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

module vtc_csr_bank
	import vtc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic host_wr_en,
	input wire logic host_rd_en,
	output logic [7:0] host_rdata,
	output logic host_rd_valid,
	input wire logic single_link,
	input wire logic [1:0] input_arrangement,
	input wire logic lr_split_mode,
	input wire logic [7:0] a_hsync_width_lower,
	input wire logic [11:0] a_visible_pixels,
	input wire logic [11:0] b_visible_pixels,
	input wire logic [11:0] a_visible_lines,
	input wire logic [11:0] b_visible_lines,
	input wire logic [7:0] a_err_events,
	input wire logic [7:0] b_err_events,
	input wire logic pll_locked,
	input wire logic a_pix_valid,
	input wire logic a_line_first,
	input wire logic b_pix_valid,
	input wire logic b_line_first,
	output logic a_pix_keep,
	output logic b_pix_keep,
	output logic [9:0] lvds_a_hsync_width,
	output logic [9:0] lvds_a_vsync_width,
	output logic [7:0] lvds_a_line_lead,
	output logic [9:0] lvds_b_hsync_width,
	output logic [9:0] lvds_b_vsync_width,
	output logic [7:0] lvds_b_line_lead,
	output logic pat_a_hsync,
	output logic pat_a_vsync,
	output logic pat_a_de,
	output logic pat_b_hsync,
	output logic pat_b_vsync,
	output logic pat_b_de,
	output logic irq_out,
	output logic irq_oe
);

	vtc_state_t q;
	vtc_state_t d;

	// Segment ends on its last count; zero-length segments are skipped, except the sync segment entered on restart, which lasts one step
	function automatic logic seg_done(vtc_gen_t g, logic [3:0][11:0] len);
		seg_done = ({1'b0, g.cnt} + 13'h0001) >= {1'b0, len[g.ph]};
	endfunction : seg_done

	function automatic vtc_gen_t gen_step(vtc_gen_t g, logic [3:0][11:0] len);
		vtc_gen_t n;
		logic [1:0] p;
		logic found;
		n = g;
		p = g.ph;
		found = 1'b0;
		if (seg_done(g, len))
		begin
			n.cnt = 12'h000;
			for (int k = 0; k < 4; k++)
			begin
				p = p + 2'h1;
				if (!found && len[p] != 12'h000)
				begin
					n.ph = vtc_phase_t'(p);
					found = 1'b1;
				end
			end
		end
		else
		begin
			n.cnt = g.cnt + 12'h001;
		end
		return n;
	endfunction : gen_step

	function automatic logic [11:0] a_zero_ext(logic [7:0] v);
		a_zero_ext = {4'h0, v};
	endfunction : a_zero_ext

	function automatic logic [7:0] wmask_of(logic [7:0] addr);
		case (addr)
			OFF_A_HSYNC_HI, OFF_B_HSYNC_HI, OFF_A_VSYNC_HI, OFF_B_VSYNC_HI: wmask_of = WMASK_UPPER2;
			OFF_PATTERN: wmask_of = WMASK_PATTERN;
			default: wmask_of = WMASK_FULL;
		endcase
	endfunction : wmask_of

	logic two_stream;
	logic b_from_a;
	logic a_run;
	logic b_run;
	logic [3:0][11:0] a_hlen;
	logic [3:0][11:0] a_vlen;
	logic [3:0][11:0] b_hlen;
	logic [3:0][11:0] b_vlen;
	logic [9:0] a_hsync;
	logic [9:0] a_vsync;
	logic [9:0] b_hsync;
	logic [9:0] b_vsync;
	logic [11:0] a_this_idx;
	logic [11:0] b_this_idx;
	logic in_vid;
	logic a_wrap;
	logic b_wrap;
	vtc_gen_t a_hn;
	vtc_gen_t b_hn;

	assign two_stream = input_arrangement == MODE_TWO_STREAM;
	assign b_from_a = !single_link && (input_arrangement == MODE_CODE_00
		|| input_arrangement == MODE_CODE_01);

	assign a_hsync = {q.vid[OFF_A_HSYNC_HI][1:0], a_hsync_width_lower};
	assign b_hsync = {q.vid[OFF_B_HSYNC_HI][1:0], q.vid[OFF_B_HSYNC_LO]};
	assign a_vsync = {q.vid[OFF_A_VSYNC_HI][1:0], q.vid[OFF_A_VSYNC_LO]};
	assign b_vsync = {q.vid[OFF_B_VSYNC_HI][1:0], q.vid[OFF_B_VSYNC_LO]};

	assign a_run = q.vid[OFF_PATTERN][PAT_A_BIT];
	assign b_run = q.vid[OFF_PATTERN][PAT_B_BIT] && two_stream;

	// Segment lengths indexed by phase: sync, lead gap, active, tail gap
	assign a_hlen = {{4'h0, q.vid[OFF_A_LINE_TAIL]}, a_visible_pixels,
		{4'h0, q.vid[OFF_A_LINE_LEAD]}, {2'h0, a_hsync}};
	assign a_vlen = {{4'h0, q.vid[OFF_A_FRAME_TAIL]}, a_visible_lines,
		{4'h0, q.vid[OFF_A_FRAME_LEAD]}, {2'h0, a_vsync}};
	assign b_hlen = {{4'h0, q.vid[OFF_B_LINE_TAIL]}, b_visible_pixels,
		{4'h0, q.vid[OFF_B_LINE_LEAD]}, {2'h0, b_hsync}};
	assign b_vlen = {{4'h0, q.vid[OFF_B_FRAME_TAIL]}, b_visible_lines,
		{4'h0, q.vid[OFF_B_FRAME_LEAD]}, {2'h0, b_vsync}};

	assign a_hn = gen_step(q.gen_a_h, a_hlen);
	assign b_hn = gen_step(q.gen_b_h, b_hlen);
	// A line ends when the horizontal phase wraps back around
	assign a_wrap = seg_done(q.gen_a_h, a_hlen) && (a_hn.ph <= q.gen_a_h.ph);
	assign b_wrap = seg_done(q.gen_b_h, b_hlen) && (b_hn.ph <= q.gen_b_h.ph);

	assign a_this_idx = a_line_first ? 12'h000 : q.a_idx;
	assign b_this_idx = b_line_first ? 12'h000 : q.b_idx;
	assign in_vid = host_addr >= OFF_A_HSYNC_HI && host_addr <= OFF_A_TAIL_TRIM;

	always_comb
	begin
		d = q;
		d.rd_valid = host_rd_en;
		d.pll_locked_q = pll_locked;

		// Flags: hardware set wins over a same-cycle clear
		d.a_flags = q.a_flags & ~((host_wr_en && host_addr == OFF_A_FLAGS)
			? (host_wdata & WMASK_A_ERR) : RST_BYTE);
		d.b_flags = q.b_flags & ~((host_wr_en && host_addr == OFF_B_FLAGS)
			? (host_wdata & WMASK_B_FLAGS) : RST_BYTE);
		d.a_flags = d.a_flags | (a_err_events & EVENT_BITS);
		d.b_flags = d.b_flags | (b_err_events & EVENT_BITS);
		if (q.pll_locked_q && !pll_locked)
		begin
			d.a_flags[PLL_UNLOCK_BIT] = 1'b1;
		end

		if (host_wr_en)
		begin
			if (in_vid)
			begin
				d.vid[host_addr] = host_wdata & wmask_of(host_addr);
			end
			case (host_addr)
				OFF_IRQ_ENABLE: d.irq_enable = host_wdata & WMASK_IRQ_ENABLE;
				OFF_A_MASKS: d.a_masks = host_wdata & WMASK_A_ERR;
				OFF_B_MASKS: d.b_masks = host_wdata & WMASK_B_MASKS;
				default: d.irq_enable = d.irq_enable;
			endcase
		end

		if (host_rd_en)
		begin
			case (host_addr)
				OFF_IRQ_ENABLE: d.rdata = q.irq_enable;
				OFF_A_MASKS: d.rdata = q.a_masks;
				OFF_B_MASKS: d.rdata = q.b_masks;
				OFF_A_FLAGS: d.rdata = q.a_flags;
				OFF_B_FLAGS: d.rdata = q.b_flags;
				default: d.rdata = in_vid ? q.vid[host_addr] : RST_BYTE;
			endcase
		end

		// Pattern timing restarts from the sync edge whenever disabled
		if (a_run)
		begin
			d.gen_a_h = a_hn;
			if (a_wrap)
			begin
				d.gen_a_v = gen_step(q.gen_a_v, a_vlen);
			end
		end
		else
		begin
			d.gen_a_h = '{ph: PH_SYNC, cnt: 12'h000};
			d.gen_a_v = '{ph: PH_SYNC, cnt: 12'h000};
		end
		if (b_run)
		begin
			d.gen_b_h = b_hn;
			if (b_wrap)
			begin
				d.gen_b_v = gen_step(q.gen_b_v, b_vlen);
			end
		end
		else
		begin
			d.gen_b_h = '{ph: PH_SYNC, cnt: 12'h000};
			d.gen_b_v = '{ph: PH_SYNC, cnt: 12'h000};
		end

		// Pixel index saturates so an overlong line cannot wrap into keep range
		if (a_pix_valid)
		begin
			d.a_idx = (a_this_idx == 12'hfff) ? a_this_idx : a_this_idx + 12'h001;
		end
		if (b_pix_valid)
		begin
			d.b_idx = (b_this_idx == 12'hfff) ? b_this_idx : b_this_idx + 12'h001;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			q <= '0;
			q.a_flags <= RST_A_FLAGS;
		end
		else
		begin
			q <= d;
		end
	end

	// Tail trim relies on the programmed visible length excluding trimmed pixels
	assign a_pix_keep = a_pix_valid
		&& (!lr_split_mode || a_this_idx < a_visible_pixels);
	assign b_pix_keep = b_pix_valid
		&& (!lr_split_mode || a_zero_ext(q.vid[OFF_B_HEAD_TRIM]) <= b_this_idx);

	assign lvds_a_hsync_width = a_hsync;
	assign lvds_a_vsync_width = a_vsync;
	assign lvds_a_line_lead = q.vid[OFF_A_LINE_LEAD];
	assign lvds_b_hsync_width = two_stream ? b_hsync : (b_from_a ? a_hsync : 10'h000);
	assign lvds_b_vsync_width = two_stream ? b_vsync : (b_from_a ? a_vsync : 10'h000);
	assign lvds_b_line_lead = two_stream ? q.vid[OFF_B_LINE_LEAD]
		: (b_from_a ? q.vid[OFF_A_LINE_LEAD] : RST_BYTE);

	assign pat_a_hsync = a_run && q.gen_a_h.ph == PH_SYNC;
	assign pat_a_vsync = a_run && q.gen_a_v.ph == PH_SYNC;
	assign pat_a_de = a_run && q.gen_a_h.ph == PH_ACT && q.gen_a_v.ph == PH_ACT;
	// Dual-link mirror: the channel A pattern also feeds LVDS B
	assign pat_b_hsync = b_run ? q.gen_b_h.ph == PH_SYNC : (b_from_a && pat_a_hsync);
	assign pat_b_vsync = b_run ? q.gen_b_v.ph == PH_SYNC : (b_from_a && pat_a_vsync);
	assign pat_b_de = b_run ? (q.gen_b_h.ph == PH_ACT && q.gen_b_v.ph == PH_ACT)
		: (b_from_a && pat_a_de);

	assign host_rdata = q.rdata;
	assign host_rd_valid = q.rd_valid;

	// Pin only ever drives high; it is released rather than driven low
	assign irq_out = 1'b1;
	assign irq_oe = q.irq_enable[IRQ_EN_BIT]
		&& |((q.a_flags & q.a_masks) | (q.b_flags & q.b_masks));

endmodule : vtc_csr_bank

`default_nettype wire

// ---- hw/vtc_pkg.sv ----
package vtc_pkg;

	// Video timing byte registers, contiguous block
	localparam logic [7:0] OFF_A_HSYNC_HI = 8'h2d;
	localparam logic [7:0] OFF_B_HSYNC_LO = 8'h2e;
	localparam logic [7:0] OFF_B_HSYNC_HI = 8'h2f;
	localparam logic [7:0] OFF_A_VSYNC_LO = 8'h30;
	localparam logic [7:0] OFF_A_VSYNC_HI = 8'h31;
	localparam logic [7:0] OFF_B_VSYNC_LO = 8'h32;
	localparam logic [7:0] OFF_B_VSYNC_HI = 8'h33;
	localparam logic [7:0] OFF_A_LINE_LEAD = 8'h34;
	localparam logic [7:0] OFF_B_LINE_LEAD = 8'h35;
	localparam logic [7:0] OFF_A_FRAME_LEAD = 8'h36;
	localparam logic [7:0] OFF_B_FRAME_LEAD = 8'h37;
	localparam logic [7:0] OFF_A_LINE_TAIL = 8'h38;
	localparam logic [7:0] OFF_B_LINE_TAIL = 8'h39;
	localparam logic [7:0] OFF_A_FRAME_TAIL = 8'h3a;
	localparam logic [7:0] OFF_B_FRAME_TAIL = 8'h3b;
	localparam logic [7:0] OFF_PATTERN = 8'h3c;
	localparam logic [7:0] OFF_B_HEAD_TRIM = 8'h3d;
	localparam logic [7:0] OFF_A_TAIL_TRIM = 8'h3e;

	// Interrupt byte registers
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'he0;
	localparam logic [7:0] OFF_A_MASKS = 8'he1;
	localparam logic [7:0] OFF_B_MASKS = 8'he2;
	localparam logic [7:0] OFF_A_FLAGS = 8'he5;
	localparam logic [7:0] OFF_B_FLAGS = 8'he6;

	// Implemented bits of each register
	localparam logic [7:0] WMASK_FULL = 8'hff;
	localparam logic [7:0] WMASK_UPPER2 = 8'h03;
	localparam logic [7:0] WMASK_PATTERN = 8'h11;
	localparam logic [7:0] WMASK_IRQ_ENABLE = 8'h01;
	localparam logic [7:0] WMASK_A_ERR = 8'hfd;
	localparam logic [7:0] WMASK_B_MASKS = 8'h7c;
	localparam logic [7:0] WMASK_B_FLAGS = 8'hfc;
	localparam logic [7:0] EVENT_BITS = 8'hfc;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_A_FLAGS = 8'h01;

	// Field positions
	localparam int PAT_A_BIT = 4;
	localparam int PAT_B_BIT = 0;
	localparam int IRQ_EN_BIT = 0;
	localparam int PLL_UNLOCK_BIT = 0;

	// Input arrangement codes
	localparam logic [1:0] MODE_TWO_STREAM = 2'h2;
	localparam logic [1:0] MODE_CODE_00 = 2'h0;
	localparam logic [1:0] MODE_CODE_01 = 2'h1;

	typedef enum logic [1:0] {PH_SYNC, PH_LEAD, PH_ACT, PH_TAIL} vtc_phase_t;

	typedef struct packed {
		vtc_phase_t ph;
		logic [11:0] cnt;
	} vtc_gen_t;

	typedef struct packed {
		logic [OFF_A_TAIL_TRIM:OFF_A_HSYNC_HI][7:0] vid;
		logic [7:0] irq_enable;
		logic [7:0] a_masks;
		logic [7:0] b_masks;
		logic [7:0] a_flags;
		logic [7:0] b_flags;
		logic pll_locked_q;
		logic [7:0] rdata;
		logic rd_valid;
		vtc_gen_t gen_a_h;
		vtc_gen_t gen_a_v;
		vtc_gen_t gen_b_h;
		vtc_gen_t gen_b_v;
		logic [11:0] a_idx;
		logic [11:0] b_idx;
	} vtc_state_t;

endpackage : vtc_pkg

// ---- verification/vtc_csr_bank_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module vtc_csr_bank_bench;
	import vtc_pkg::*;
	logic core_clk, reset_n, host_wr_en, host_rd_en, host_rd_valid, single_link, lr_split_mode;
	logic [7:0] host_addr, host_wdata, host_rdata, a_hsync_width_lower, a_err_events, b_err_events;
	logic [1:0] input_arrangement;
	logic [11:0] a_visible_pixels, b_visible_pixels, a_visible_lines, b_visible_lines;
	logic pll_locked, a_pix_valid, a_line_first, b_pix_valid, b_line_first, a_pix_keep, b_pix_keep;
	logic [9:0] lvds_a_hsync_width, lvds_a_vsync_width, lvds_b_hsync_width, lvds_b_vsync_width;
	logic [7:0] lvds_a_line_lead, lvds_b_line_lead;
	logic pat_a_hsync, pat_a_vsync, pat_a_de, pat_b_hsync, pat_b_vsync, pat_b_de, irq_out, irq_oe;
	int failures, n_tests, nh, nd, nb, nv;
	vtc_csr_bank vtc_csr_bank_inst (.*);
	vtc_host_model vtc_host_model_inst (.*);
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task end_of_test();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		vtc_host_model_inst.rd(a, d, ok);
		if (!ok)
		begin
			failures++;
			$display("mismatch read_answer expected 1 seen 0");
			end_of_test();
		end
		else
		begin
			chk("rdata", {2'h0, e}, {2'h0, d});
		end
	endtask : rdc
	task wr(input logic [7:0] a, input logic [7:0] d);
		vtc_host_model_inst.wr(a, d);
	endtask : wr
	task pulse(input logic [7:0] a, input logic [7:0] b);
		{a_err_events, b_err_events} = {a, b};
		@(posedge core_clk) #1;
		{a_err_events, b_err_events} = 16'h0;
	endtask : pulse
	function automatic logic [7:0] msk(input int a);
		case (a)
			'h2d, 'h2f, 'h31, 'h33: return 8'h03;
			'h3c: return 8'h11;
			'he0: return 8'h01;
			'he1: return 8'hfd;
			'he2: return 8'h7c;
			default: return (a > 'h2d && a < 'h3f) ? 8'hff : 8'h00;
		endcase
	endfunction : msk
	task t_reset();
		for (int a = 'h2c; a < 'h100; a++)
			rdc(8'(a), a == 'he5 ? 8'h01 : 8'h00);
		$display("done reset values");
	endtask : t_reset
	task t_pattern();
		a_hsync_width_lower = 8'h02;
		vtc_host_model_inst.set_len(12'h003, 8'h00);
		wr(8'h34, 8'h01);
		wr(8'h38, 8'h01);
		wr(8'h3c, 8'h10);
		chk("vsync_on", 10'h3, {8'h0, pat_a_vsync, pat_b_vsync});
		repeat (12) @(posedge core_clk);
		{nh, nd, nb, nv} = 0;
		repeat (7)
		begin
			@(posedge core_clk) #1;
			nh += pat_a_hsync;
			nd += pat_a_de;
			nb += pat_b_hsync;
			nv += pat_b_de;
		end
		chk("hsync_count", 10'd2, 10'(nh));
		chk("de_count", 10'd3, 10'(nd));
		chk("b_hsync_count", 10'd2, 10'(nb));
		chk("b_de_count", 10'd3, 10'(nv));
		wr(8'h3c, 8'h00);
		chk("pattern_off", 10'h0, {8'h0, pat_a_hsync, pat_a_de});
		$display("done pattern");
	endtask : t_pattern
	task t_rw();
		for (int a = 'h2c; a < 'h100; a++)
			wr(8'(a), 8'hff);
		for (int a = 'h2c; a < 'h100; a++)
			rdc(8'(a), msk(a));
		a_hsync_width_lower = 8'h5a;
		@(posedge core_clk) #1;
		chk("a_hsync", 10'h35a, lvds_a_hsync_width);
		chk("a_vsync", 10'h3ff, lvds_a_vsync_width);
		chk("a_lead", 10'h0ff, {2'h0, lvds_a_line_lead});
		input_arrangement = MODE_TWO_STREAM;
		@(posedge core_clk) #1;
		chk("b_vsync", 10'h3ff, lvds_b_vsync_width);
		chk("b_hsync", 10'h3ff, lvds_b_hsync_width);
		chk("b_lead", 10'h0ff, {2'h0, lvds_b_line_lead});
		input_arrangement = MODE_CODE_01;
		@(posedge core_clk) #1;
		chk("b_from_a", 10'h35a, lvds_b_hsync_width);
		single_link = 1'b1;
		@(posedge core_clk) #1;
		chk("b_off", 10'h000, lvds_b_hsync_width);
		$display("done access");
	endtask : t_rw
	task t_irq();
		pulse(8'hff, 8'h00);
		rdc(8'he5, 8'hfc);
		chk("irq_oe", 10'h1, {9'h0, irq_oe});
		wr(8'he5, 8'h00);
		rdc(8'he5, 8'hfc);
		wr(8'he1, 8'h00);
		chk("irq_oe", 10'h0, {9'h0, irq_oe});
		wr(8'he5, 8'hfc);
		wr(8'he1, 8'hfd);
		pulse(8'h00, 8'h80);
		rdc(8'he6, 8'h80);
		chk("irq_oe", 10'h0, {9'h0, irq_oe});
		pulse(8'h00, 8'h04);
		chk("irq_oe", 10'h1, {9'h0, irq_oe});
		wr(8'he0, 8'h00);
		chk("irq_oe", 10'h0, {9'h0, irq_oe});
		wr(8'he0, 8'h01);
		wr(8'he6, 8'h84);
		chk("irq_oe", 10'h0, {9'h0, irq_oe});
		pll_locked = 1'b0;
		rdc(8'he5, 8'h01);
		$display("done interrupt");
	endtask : t_irq
	task t_trim();
		lr_split_mode = 1'b1;
		wr(8'h3d, 8'h03);
		wr(8'h3e, 8'h03);
		vtc_host_model_inst.set_len(12'h008, 8'h03);
		for (int i = 0; i < 8; i++)
		begin
			{a_pix_valid, b_pix_valid, a_line_first, b_line_first} = {2'b11, {2{i == 0}}};
			#1 chk("a_keep", 10'(i < 5), {9'h0, a_pix_keep});
			chk("b_keep", 10'(i >= 3), {9'h0, b_pix_keep});
			@(posedge core_clk) #1;
		end
		{lr_split_mode, a_pix_valid, b_pix_valid} = 3'b000;
		$display("done trim");
	endtask : t_trim
	initial
	begin
		{failures, n_tests} = 0;
		{reset_n, single_link, lr_split_mode, pll_locked, a_pix_valid, b_pix_valid} = 6'b000100;
		{a_line_first, b_line_first, input_arrangement} = 4'h0;
		{a_hsync_width_lower, a_err_events, b_err_events} = 24'h0;
		{b_visible_pixels, a_visible_lines, b_visible_lines} = {12'h005, 12'h002, 12'h002};
		repeat (5) @(posedge core_clk);
		#1 reset_n = 1'b1;
		t_reset();
		t_pattern();
		t_rw();
		t_irq();
		t_trim();
		end_of_test();
	end
endmodule : vtc_csr_bank_bench
`default_nettype wire

// ---- verification/vtc_csr_bank_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module vtc_csr_bank_checker (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_wdata,
	input wire logic host_wr_en,
	input wire logic host_rd_en,
	input wire logic host_rd_valid,
	input wire logic single_link,
	input wire logic [1:0] input_arrangement,
	input wire logic lr_split_mode,
	input wire logic [7:0] a_hsync_width_lower,
	input wire logic a_pix_valid,
	input wire logic b_pix_valid,
	input wire logic a_pix_keep,
	input wire logic b_pix_keep,
	input wire logic [9:0] lvds_a_hsync_width,
	input wire logic [9:0] lvds_b_hsync_width,
	input wire logic pat_a_hsync,
	input wire logic pat_a_de,
	input wire logic pat_b_hsync,
	input wire logic pat_b_de,
	input wire logic irq_out,
	input wire logic irq_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_read_answer: assert property (host_rd_en |=> host_rd_valid)
		else $error("read not answered");
	a_read_cause: assert property ($rose(host_rd_valid) |-> $past(host_rd_en))
		else $error("read answer without request");
	a_pin_level: assert property (irq_oe |-> irq_out)
		else $error("pin driven low");
	a_pin_disable: assert property (
		host_wr_en && host_addr == 8'he0 && !host_wdata[0] |=> !irq_oe)
		else $error("pin driven while disabled");
	a_sync_low_byte: assert property (lvds_a_hsync_width[7:0] == a_hsync_width_lower)
		else $error("hsync low byte wrong");
	a_trim_bypass: assert property (
		!lr_split_mode |-> a_pix_keep == a_pix_valid && b_pix_keep == b_pix_valid)
		else $error("pixel dropped outside split mode");
	a_b_mirrors_a: assert property (
		!single_link && !input_arrangement[1] |-> lvds_b_hsync_width == lvds_a_hsync_width)
		else $error("b timing not from a");
	a_b_unused: assert property (
		single_link && !input_arrangement[1] |-> lvds_b_hsync_width == 10'h000)
		else $error("b timing active");
	a_pat_b_mirror: assert property (
		!single_link && !input_arrangement[1]
		|-> pat_b_de == pat_a_de && pat_b_hsync == pat_a_hsync)
		else $error("b pattern differs");
	a_pat_phases: assert property (pat_a_de |-> !pat_a_hsync)
		else $error("sync during active");
endmodule : vtc_csr_bank_checker
bind vtc_csr_bank vtc_csr_bank_checker vtc_csr_bank_checker_inst (.*);
`default_nettype wire

// ---- verification/vtc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module vtc_host_model (
	input wire logic core_clk,
	output logic [7:0] host_addr,
	output logic [7:0] host_wdata,
	output logic host_wr_en,
	output logic host_rd_en,
	input wire logic [7:0] host_rdata,
	input wire logic host_rd_valid,
	output logic [11:0] a_visible_pixels
);
	initial
	begin
		{host_addr, host_wdata, host_wr_en, host_rd_en} = 18'h0;
		a_visible_pixels = 12'h000;
	end
	// Released bus shows inverted values so a stale address cannot pass
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) #1;
		{host_addr, host_wdata, host_wr_en} = {a, d, 1'b1};
		@(posedge core_clk) #1;
		{host_addr, host_wdata, host_wr_en} = {~a, ~d, 1'b0};
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		@(posedge core_clk) #1;
		{host_addr, host_rd_en} = {a, 1'b1};
		@(posedge core_clk) #1;
		{host_addr, host_rd_en} = {~a, 1'b0};
		repeat (4)
		begin
			if (!ok && host_rd_valid === 1'b1)
				{d, ok} = {host_rdata, 1'b1};
			if (!ok)
				@(posedge core_clk) #1;
		end
	endtask : rd
	task set_len(input logic [11:0] full, input logic [7:0] trim);
		a_visible_pixels = full - {4'h0, trim};
	endtask : set_len
endmodule : vtc_host_model
`default_nettype wire
